// ---- src/kmf_front_panel.sv ----
// front-panel keypad, menu, password and function-input control
`timescale 1ns/1ps
//
// Overview of operation
// - up/down alone adjust setpoint, or manual level
// - set in display opens quick access menu
// - both held 1 s open menu, password
// - function key held 1 s toggles action
// - set edits, second set confirms and stores
// - browse steps parameters, edit changes value
// - brief both cancels edit, 0.5 s exits
// - two minutes idle returns to display
// - leds follow output one, two, three
// - key and level input share action
// - function key ignored while level active
// - action start and stop show message
// - function none makes both inert
// - action selects night setpoint over day
// - lock action disables all but function
// - manual actions force chosen output manual
// - run/stop action halts all outputs
// - every parameter change goes to storage
// - password digits entered, compared on last
module kmf_front_panel
   import kmf_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int IDLE_TICKS = IDLE_MS
)
(
   // clock and reset
   input logic clk,
   input logic rst_n,
   // operator keys and level input
   input kmf_keys_t keys,
   // present state of the three outputs
   input logic [2:0] out_on,
   // indicators and display
   output logic [2:0] led_o,
   output kmf_disp_t disp_o,
   // effects of the function action
   output logic sp_night_o,
   output logic kbd_lock_o,
   output logic [3:0] manual_force_o,
   output logic control_run_o,
   // non-volatile store write
   output kmf_save_t nv_save_o,
   // axi4-lite slave
   input logic [7:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [7:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic tick_reg;
   logic [15:0] tick_cnt_reg;
   kmf_keys_t k;
   kmf_keys_t prev_reg;
   logic [15:0] par_reg [NPAR];
   kmf_state_t st_reg, st_next;
   logic [2:0] idx_reg, idx_next;
   logic [15:0] edit_reg, edit_next;
   logic [15:0] code_reg, code_next;
   logic [1:0] dig_reg, dig_next;
   logic quick_reg, quick_next;
   logic combo_reg, used_reg;
   logic [9:0] combo_ms_reg, fn_ms_reg;
   logic [16:0] idle_reg;
   logic act_reg, act_next;
   kmf_msg_t msg_reg, msg_next;
   kmf_save_t sv;
   logic [3:0] man_w;

   // 1 ms enable pulse
   always_ff @(posedge clk)
   begin
      if (!rst_n || tick_cnt_reg == 16'(TICK_CYCLES - 1))
         tick_cnt_reg <= 16'h0000;
      else
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= rst_n && tick_cnt_reg == 16'(TICK_CYCLES - 1);
   end

   // inputs cleaned before any decoding, so bounce never yields two presses
   kmf_debounce u_deb (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick_reg),
      .raw(keys),
      .clean(k)
   );

   // action effects; lock gates every key except the function key
   logic [15:0] fsel;
   logic lock_w, night_w, run_w, ku, kd, ks, man1;
   assign fsel = par_reg[P_FUNC];
   assign lock_w = act_reg && fsel == F_LOCK;
   assign night_w = act_reg && fsel == F_NIGHT;
   assign run_w = !(act_reg && fsel == F_RUN_STOP);
   assign ku = k.key_up && !lock_w;
   assign kd = k.key_down && !lock_w;
   assign ks = k.key_set && !lock_w;
   assign man1 = man_w[0];

   // one manual-force bit per output, codes consecutive from F_MAN1
   genvar gi;
   for (gi = 0; gi < 4; gi++)
   begin : g_man
      assign man_w[gi] = act_reg && fsel == F_MAN1 + 16'(gi);
   end

   // key events; single up and down presses act on release so a chord is never misread, set acts on press
   logic both, up_rel, dn_rel, ev_up, ev_dn, ev_set, ev_short, ev_long, ev_half;
   logic ev_fn, lv_rise, lv_fall, ev_idle, any_key;
   assign both = ku && kd;
   assign up_rel = prev_reg.key_up && !ku;
   assign dn_rel = prev_reg.key_down && !kd;
   assign ev_up = up_rel && !kd && !combo_reg;
   assign ev_dn = dn_rel && !ku && !combo_reg;
   assign ev_set = ks && !prev_reg.key_set;
   assign ev_short = combo_reg && !ku && !kd && !used_reg &&
                     combo_ms_reg < 10'(HALF_MS);
   assign ev_long = both && tick_reg && !used_reg && combo_ms_reg == 10'(LONG_MS - 1);
   assign ev_half = both && tick_reg && !used_reg && combo_ms_reg == 10'(HALF_MS - 1);
   assign ev_fn = k.key_func && !k.level_input && tick_reg &&
                  fn_ms_reg == 10'(LONG_MS - 1);
   assign lv_rise = k.level_input && !prev_reg.level_input;
   assign lv_fall = !k.level_input && prev_reg.level_input;
   assign any_key = k.key_up || k.key_down || k.key_set || k.key_func;
   assign ev_idle = tick_reg && idle_reg == 17'(IDLE_TICKS - 1);

   // hold timers count ms ticks and saturate
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prev_reg <= '0;
         combo_reg <= 1'b0;
         used_reg <= 1'b0;
         combo_ms_reg <= 10'h000;
         fn_ms_reg <= 10'h000;
         idle_reg <= 17'h00000;
      end
      else
      begin
         prev_reg <= '{ku, kd, ks, k.key_func, k.level_input};
         combo_reg <= both || (combo_reg && (ku || kd));
         used_reg <= (ku || kd) && (used_reg || (ev_half && st_reg != ST_MEAS) ||
                     (ev_long && st_reg == ST_MEAS));
         if (!both)
            combo_ms_reg <= 10'h000;
         else if (tick_reg && combo_ms_reg != 10'h3ff)
            combo_ms_reg <= combo_ms_reg + 10'h001;
         if (!k.key_func)
            fn_ms_reg <= 10'h000;
         else if (tick_reg && fn_ms_reg != 10'h3ff)
            fn_ms_reg <= fn_ms_reg + 10'h001;
         if (any_key || st_reg == ST_MEAS || ev_idle)
            idle_reg <= 17'h00000;
         else if (tick_reg)
            idle_reg <= idle_reg + 17'h00001;
      end
   end

   // key and level input drive one action; level edges set it, key toggles
   always_comb
   begin
      act_next = act_reg;
      if (fsel == F_NONE)
         act_next = 1'b0;
      else if (lv_rise)
         act_next = 1'b1;
      else if (lv_fall)
         act_next = 1'b0;
      else if (ev_fn)
         act_next = !act_reg;
      msg_next = msg_reg;
      if (act_next != act_reg)
      begin
         case (fsel)
            F_NIGHT: msg_next = act_next ? MSG_NIGHT : MSG_DAY;
            F_LOCK: msg_next = act_next ? MSG_LOCK : MSG_LOCK_OFF;
            F_RUN_STOP: msg_next = act_next ? MSG_STOP : MSG_RUN;
            default: msg_next = act_next ? MSG_MANUAL_ON : MSG_MANUAL_OFF;
         endcase
      end
   end

   // measurement-mode step target follows output-one manual (man1) and night selection
   logic [2:0] tgt;
   logic [3:0] dig_val;
   assign tgt = man1 ? P_MAN : (night_w ? P_NIGHT : P_DAY);
   assign dig_val = code_reg[{dig_reg, 2'b00} +: 4];

   // menu state machine
   always_comb
   begin
      st_next = st_reg;
      idx_next = idx_reg;
      edit_next = edit_reg;
      code_next = code_reg;
      dig_next = dig_reg;
      quick_next = quick_reg;
      sv = '0;
      case (st_reg)
         ST_MEAS:
         begin
            if (ev_up || ev_dn)
               sv = '{1'b1, tgt, ev_up ? par_reg[tgt] + 16'h0001 : par_reg[tgt] - 16'h0001};
            if (ev_set)
            begin
               st_next = ST_BROWSE;
               quick_next = 1'b1;
               idx_next = P_DAY;
            end
            else if (ev_long)
            begin
               st_next = par_reg[P_PASSWORD_PROTECT_ENABLE] != 16'h0000 ? ST_PASS : ST_BROWSE;
               quick_next = 1'b0;
               idx_next = P_DAY;
               code_next = 16'h0000;
               dig_next = 2'h0;
            end
         end
         ST_PASS:
         begin
            if (ev_up)
               code_next[{dig_reg, 2'b00} +: 4] = dig_val == DIG_MAX ? 4'h0 : dig_val + 4'h1;
            else if (ev_dn)
               code_next[{dig_reg, 2'b00} +: 4] = dig_val == 4'h0 ? DIG_MAX : dig_val - 4'h1;
            else if (ev_set && dig_reg == PW_LAST)
               st_next = code_reg == par_reg[P_PASS] ? ST_BROWSE : ST_MEAS;
            else if (ev_set)
               dig_next = dig_reg + 2'h1;
         end
         ST_BROWSE:
         begin
            if (ev_up)
               idx_next = idx_reg == P_LAST ? 3'h0 : idx_reg + 3'h1;
            else if (ev_dn)
               idx_next = idx_reg == 3'h0 ? P_LAST : idx_reg - 3'h1;
            else if (ev_set)
            begin
               st_next = ST_EDIT;
               edit_next = par_reg[idx_reg];
            end
         end
         ST_EDIT:
         begin
            if (ev_up)
               edit_next = edit_reg + 16'h0001;
            else if (ev_dn)
               edit_next = edit_reg - 16'h0001;
            else if (ev_set)
            begin
               sv = '{1'b1, idx_reg, edit_reg};
               st_next = ST_BROWSE;
            end
            else if (ev_short)
               st_next = ST_BROWSE;
         end
         default: st_next = ST_MEAS;
      endcase
      if (st_reg != ST_MEAS && (ev_half || ev_idle))
      begin
         st_next = ST_MEAS;
         sv = '0;
      end
   end

   // axi4-lite write: address and data latched independently, in either order
   logic aw_full_reg, w_full_reg, wr_do, aw_full_next, w_full_next, bvalid_next;
   logic [7:0] aw_addr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_par, rd_par, rd_stat, rvalid_next;
   logic [2:0] wi;
   logic [15:0] wval;
   kmf_stat_t stat;
   assign wr_do = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign aw_full_next = !wr_do && (aw_full_reg || (s_axi_awvalid && s_axi_awready));
   assign w_full_next = !wr_do && (w_full_reg || (s_axi_wvalid && s_axi_wready));
   assign bvalid_next = wr_do || (s_axi_bvalid && !s_axi_bready);
   assign wi = aw_addr_reg[4:2];
   assign wr_par = wr_do && aw_addr_reg[7:5] == A_PAR_BLK && aw_addr_reg[1:0] == 2'b00;
   assign wval = {wstrb_reg[1] ? wdata_reg[15:8] : par_reg[wi][15:8],
                  wstrb_reg[0] ? wdata_reg[7:0] : par_reg[wi][7:0]};
   assign rd_par = s_axi_araddr[7:5] == A_PAR_BLK && s_axi_araddr[1:0] == 2'b00;
   assign rd_stat = s_axi_araddr == A_STAT;
   assign rvalid_next = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
   assign stat = '{quick_reg, run_w, night_w, lock_w, act_reg, man_w, st_reg};

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OK;
         aw_addr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end
      else
      begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         s_axi_awready <= !aw_full_next && !bvalid_next;
         s_axi_wready <= !w_full_next && !bvalid_next;
         s_axi_bvalid <= bvalid_next;
         s_axi_arready <= !rvalid_next;
         s_axi_rvalid <= rvalid_next;
         if (s_axi_awvalid && s_axi_awready)
            aw_addr_reg <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_do) // status is read-only but answers okay
            s_axi_bresp <= (wr_par || aw_addr_reg == A_STAT) ? RESP_OK : RESP_ERR;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rdata <= rd_par ? {16'h0000, par_reg[s_axi_araddr[4:2]]} :
                           rd_stat ? {21'h000000, stat} : 32'h00000000;
            s_axi_rresp <= (rd_par || rd_stat) ? RESP_OK : RESP_ERR;
         end
      end
   end

   // parameter table; a bus write wins over a keypad store in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NPAR; i++)
            par_reg[i] <= RST_PAR[i];
         nv_save_o <= '0;
      end
      else
      begin
         if (wr_par)
            par_reg[wi] <= wval;
         else if (sv.stb)
            par_reg[sv.idx] <= sv.value;
         nv_save_o <= wr_par ? kmf_save_t'{1'b1, wi, wval} : sv;
      end
   end

   // state and output registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_reg <= ST_MEAS;
         idx_reg <= 3'h0;
         edit_reg <= 16'h0000;
         code_reg <= 16'h0000;
         dig_reg <= 2'h0;
         quick_reg <= 1'b0;
         act_reg <= 1'b0;
         msg_reg <= MSG_NONE;
         led_o <= 3'h0;
         disp_o <= '0;
         sp_night_o <= 1'b0;
         kbd_lock_o <= 1'b0;
         manual_force_o <= 4'h0;
         control_run_o <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
         idx_reg <= idx_next;
         edit_reg <= edit_next;
         code_reg <= code_next;
         dig_reg <= dig_next;
         quick_reg <= quick_next;
         act_reg <= act_next;
         msg_reg <= msg_next;
         led_o <= out_on;
         disp_o <= '{st_reg, idx_reg,
                     st_reg == ST_EDIT ? edit_reg : st_reg == ST_PASS ? code_reg :
                     st_reg == ST_BROWSE ? par_reg[idx_reg] : par_reg[tgt],
                     st_reg == ST_EDIT || st_reg == ST_PASS, msg_reg};
         sp_night_o <= night_w;
         kbd_lock_o <= lock_w;
         manual_force_o <= man_w;
         control_run_o <= run_w;
      end
   end

   sequence s_pw_ok;
      st_reg == ST_PASS && ev_set && dig_reg == PW_LAST && code_reg == par_reg[P_PASS] &&
         !ev_up && !ev_dn;
   endsequence
   // a step event in the same cycle takes priority over set
   sequence s_edit_store;
      st_reg == ST_EDIT && ev_set && !ev_up && !ev_dn && !ev_half && !ev_idle && !wr_par;
   endsequence

   AST_LED: assert property ($stable(out_on) |=> led_o == $past(out_on))
      else $error("led does not follow output state");
   AST_QUICK: assert property (st_reg == ST_MEAS && ev_set |=> st_reg == ST_BROWSE)
      else $error("set did not open quick menu");
   AST_MENU: assert property (st_reg == ST_MEAS && ev_long && !ev_set |=>
      st_reg == ($past(par_reg[P_PASSWORD_PROTECT_ENABLE]) != 16'h0000 ? ST_PASS : ST_BROWSE))
      else $error("long chord did not open menu");
   AST_STEP: assert property (st_reg == ST_MEAS && ev_up && !man1 && !night_w && !wr_par
      |=> nv_save_o.stb && nv_save_o.idx == P_DAY)
      else $error("up did not adjust day setpoint");
   AST_STORE: assert property (s_edit_store |=> nv_save_o.stb &&
      nv_save_o.value == $past(edit_reg) ##1 disp_o.mode == ST_BROWSE)
      else $error("edit confirm did not store");
   AST_CANCEL: assert property (st_reg == ST_EDIT && ev_short && !ev_set && !ev_idle |=>
      st_reg == ST_BROWSE && !nv_save_o.stb)
      else $error("cancel did not discard");
   AST_EXIT: assert property (st_reg != ST_MEAS && (ev_half || ev_idle)
      |=> st_reg == ST_MEAS ##1 !disp_o.flash)
      else $error("hold or idle did not leave menu");
   AST_PASS: assert property (s_pw_ok and !ev_half and !ev_idle |=> st_reg == ST_BROWSE)
      else $error("good password refused");
   AST_FIGN: assert property (k.level_input && $past(k.level_input) && !lv_fall &&
      fsel != F_NONE
      |=> act_reg == $past(act_reg))
      else $error("function key acted while level input active");
   AST_NONE: assert property (fsel == F_NONE [*3] |-> !kbd_lock_o && control_run_o &&
      manual_force_o == 4'h0 && !sp_night_o)
      else $error("action effective with none selected");
   AST_MSG: assert property (fsel != F_NONE && act_next != act_reg && !wr_par
      |=> ##1 disp_o.msg != MSG_NONE)
      else $error("action change not announced");
   AST_LOCK: assert property (lock_w && st_reg == ST_MEAS |=> st_reg == ST_MEAS)
      else $error("locked keypad changed mode");
   AST_BRESP: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before ready");
endmodule

// ---- src/kmf_pkg.sv ----
// constants and types shared by the front-panel keypad block
package kmf_pkg;
   // timing base, all long counts run on a 1 ms tick
   localparam int CLK_HZ = 50000000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
   localparam int LONG_MS = 1000;
   localparam int HALF_MS = 500;
   localparam int IDLE_MIN = 2;
   localparam int IDLE_MS = IDLE_MIN * 60000;
   localparam logic [3:0] DEB_MS = 4'ha;

   // parameter table slots
   localparam int NPAR = 8;
   localparam logic [2:0] P_DAY = 3'h0;
   localparam logic [2:0] P_NIGHT = 3'h1;
   localparam logic [2:0] P_MAN = 3'h2;
   localparam logic [2:0] P_PASS = 3'h3;
   localparam logic [2:0] P_PASSWORD_PROTECT_ENABLE = 3'h4;
   localparam logic [2:0] P_FUNC = 3'h5;
   localparam logic [2:0] P_LAST = 3'h7;
   localparam logic [15:0] RST_PAR [NPAR] = '{16'h00c8, 16'h0096, 16'h0000, 16'h0000,
                                             16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // function-select codes
   localparam logic [15:0] F_NONE = 16'h0000;
   localparam logic [15:0] F_NIGHT = 16'h0001;
   localparam logic [15:0] F_LOCK = 16'h0002;
   localparam logic [15:0] F_MAN1 = 16'h0003;
   localparam logic [15:0] F_RUN_STOP = 16'h0007;

   // password entry
   localparam logic [1:0] PW_LAST = 2'h3;
   localparam logic [3:0] DIG_MAX = 4'h9;

   // register bus map
   localparam logic [2:0] A_PAR_BLK = 3'h0;
   localparam logic [7:0] A_STAT = 8'h20;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef enum logic [1:0] {ST_MEAS, ST_PASS, ST_BROWSE, ST_EDIT} kmf_state_t;

   typedef enum logic [3:0] {
      MSG_NONE, MSG_DAY, MSG_NIGHT, MSG_LOCK, MSG_LOCK_OFF,
      MSG_MANUAL_ON, MSG_MANUAL_OFF, MSG_RUN, MSG_STOP
   } kmf_msg_t;

   typedef struct packed {
      logic key_up;
      logic key_down;
      logic key_set;
      logic key_func;
      logic level_input;
   } kmf_keys_t;

   typedef struct packed {
      kmf_state_t mode;
      logic [2:0] idx;
      logic [15:0] value;
      logic flash;
      kmf_msg_t msg;
   } kmf_disp_t;

   typedef struct packed {
      logic stb;
      logic [2:0] idx;
      logic [15:0] value;
   } kmf_save_t;

   typedef struct packed {
      logic quick;
      logic run;
      logic night;
      logic lock;
      logic act;
      logic [3:0] manual;
      kmf_state_t mode;
   } kmf_stat_t;
endpackage

// ---- src/kmf_debounce.sv ----
// synchroniser and debouncer for the keys and the level input
`timescale 1ns/1ps
module kmf_debounce
   import kmf_pkg::*;
(
   // clock, reset, 1 ms tick
   input logic clk,
   input logic rst_n,
   input logic tick,
   // raw and clean levels
   input kmf_keys_t raw,
   output kmf_keys_t clean
);
   // one filter per input bit; a level must hold DEB_MS ticks to be taken
   genvar i;
   for (i = 0; i < $bits(kmf_keys_t); i++)
   begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic st_reg;
      logic [3:0] cnt_reg;
      always_ff @(posedge clk)
      begin
         if (!rst_n)
         begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            st_reg <= 1'b0;
            cnt_reg <= 4'h0;
         end
         else
         begin
            s1_reg <= raw[i];
            s2_reg <= s1_reg;
            if (s2_reg == st_reg)
               cnt_reg <= 4'h0;
            else if (tick && cnt_reg == DEB_MS - 4'h1)
            begin
               st_reg <= s2_reg;
               cnt_reg <= 4'h0;
            end
            else if (tick)
               cnt_reg <= cnt_reg + 4'h1;
         end
      end
      assign clean[i] = st_reg;
   end
endmodule

// ---- test/kmf_operator.sv ----
// operator keys and contact input model, with contact chatter
`timescale 1ns/1ps
module kmf_operator
   import kmf_pkg::*;
(
   // clock
   input wire logic clk,
   // wanted and delivered levels
   input wire kmf_keys_t want,
   output kmf_keys_t keys
);
   kmf_keys_t last_reg = '0;
   kmf_keys_t flip_reg = '0;
   logic [1:0] bounce_reg = 2'h0;
   // a change swings between old and new level a few cycles, so the debouncer is exercised
   always @(posedge clk)
   begin
      if (want != last_reg)
      begin
         bounce_reg <= 2'h3;
         flip_reg <= want ^ last_reg;
      end
      else if (bounce_reg != 2'h0)
         bounce_reg <= bounce_reg - 2'h1;
      last_reg <= want;
      keys <= bounce_reg[0] ? want ^ flip_reg : want; // steady levels after chatter
   end
endmodule

// ---- test/tb_kmf_front_panel.sv ----
// self-checking bench for the front-panel keypad block
`timescale 1ns/1ps
module tb_kmf_front_panel
   import kmf_pkg::*;
;
   // key bits: up, down, set, function, level input
   localparam logic [4:0] K_UP = 5'h10;
   localparam logic [4:0] K_UD = 5'h18;
   localparam logic [4:0] K_SET = 5'h04;
   localparam logic [4:0] K_FN = 5'h02;
   localparam logic [4:0] K_LV = 5'h01;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   kmf_keys_t want = '0;
   kmf_keys_t keys;
   logic [2:0] out_on = 3'h0;
   logic [2:0] led_o;
   kmf_disp_t disp_o;
   logic sp_night_o, kbd_lock_o, control_run_o;
   logic [3:0] manual_force_o;
   kmf_save_t nv_save_o;
   kmf_save_t nv = '0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int failures = 0;
   int n_checks = 0;

   kmf_operator u_kmf_operator (.clk, .want, .keys);
   // short tick and idle span keep the run brief
   kmf_front_panel #(.TICK_CYCLES(2), .IDLE_TICKS(200)) u_kmf_front_panel (
      .clk, .rst_n, .keys, .out_on, .led_o, .disp_o, .sp_night_o, .kbd_lock_o,
      .manual_force_o, .control_run_o, .nv_save_o, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   initial
   begin
      forever #10 clk = ~clk;
   end
   // keep the last store pulse
   always @(posedge clk)
      if (nv_save_o.stb === 1'b1) nv <= nv_save_o;
   // hang guard
   initial
   begin
      #1000000;
      failures++;
      results();
   end

   task results;
      if (failures == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // hold a key pattern for t ticks plus the debounce span
   task hold(input logic [4:0] k, input int t);
      want <= k;
      cyc(2 * t + 50);
   endtask
   // bus writes only while the keypad is idle
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, RESP_OK);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask

   task t_reset;
      chk(control_run_o, 1'b1);
      rd(8'h00, 32'h00c8, RESP_OK);
      rd(8'h14, 32'h0, RESP_OK);
      rd(8'h40, 32'h0, RESP_ERR);
      out_on <= 3'h5;
      cyc(3);
      chk(led_o, 3'h5);
      hold(K_UP, 5);
      hold('0, 0);
      chk(nv, {1'b1, 3'h0, 16'h00c9});
      chk(disp_o.value, 16'h00c9);
      hold(K_FN, 1100);
      hold(K_LV, 0);
      chk(sp_night_o, 1'b0);
      hold('0, 0);
   endtask
   task t_night;
      wr(8'h14, 32'(F_NIGHT));
      hold(K_LV, 0);
      chk(sp_night_o, 1'b1);
      chk(disp_o.value, 16'h0096);
      chk(disp_o.msg, MSG_NIGHT);
      hold(K_LV | K_FN, 1100);
      hold(K_LV, 0);
      chk(sp_night_o, 1'b1);
      hold('0, 0);
      chk(disp_o.msg, MSG_DAY);
      hold(K_FN, 1100);
      hold('0, 0);
      chk(sp_night_o, 1'b1);
      wr(8'h14, 32'h0); // none drops the action left on by the key
      wr(8'h14, 32'(F_LOCK));
      hold(K_LV, 0);
      chk(kbd_lock_o, 1'b1);
      chk(disp_o.msg, MSG_LOCK);
      hold(K_LV | K_SET, 5);
      hold(K_LV, 0);
      chk(disp_o.mode, ST_MEAS);
      hold('0, 0);
      chk(disp_o.msg, MSG_LOCK_OFF);
   endtask
   task t_codes;
      for (int c = 3; c <= 7; c++)
      begin
         wr(8'h14, 32'(c));
         hold(K_LV, 0);
         chk(manual_force_o, (c < 7) ? 4'h1 << (c - 3) : 4'h0);
         chk(control_run_o, c != 7);
         chk(disp_o.msg, (c < 7) ? MSG_MANUAL_ON : MSG_STOP);
         hold('0, 0);
         chk(manual_force_o, 4'h0);
         chk(disp_o.msg, (c < 7) ? MSG_MANUAL_OFF : MSG_RUN);
      end
      wr(8'h14, 32'h0);
   endtask
   task t_menu;
      hold(K_SET, 5);
      chk(disp_o.mode, ST_BROWSE);
      hold(K_UP, 5);
      hold('0, 0);
      chk(disp_o.idx, 3'h1);
      hold(K_SET, 5);
      hold('0, 0);
      chk(disp_o.flash, 1'b1);
      hold(K_UP, 5);
      hold('0, 0);
      hold(K_SET, 5);
      hold('0, 0);
      chk(nv, {1'b1, 3'h1, 16'h0097});
      hold(K_SET, 5);
      hold(K_UP, 5);
      hold('0, 0);
      chk(disp_o.value, 16'h0098);
      hold(K_UD, 20);
      hold('0, 0);
      chk(disp_o.value, 16'h0097);
      chk(disp_o.flash, 1'b0);
      hold(K_UD, 600);
      hold('0, 0);
      chk(disp_o.mode, ST_MEAS);
      rd(8'h04, 32'h0097, RESP_OK);
      hold(K_SET, 5);
      hold('0, 0);
      chk(disp_o.mode, ST_BROWSE);
      cyc(600);
      chk(disp_o.mode, ST_MEAS);
   endtask
   task t_pass;
      hold(K_UD, 1100);
      hold('0, 0);
      chk(disp_o.mode, ST_BROWSE);
      hold(K_UD, 600);
      hold('0, 0);
      wr(8'h10, 32'h1);
      hold(K_UD, 1100);
      hold('0, 0);
      chk(disp_o.mode, ST_PASS);
      repeat (4)
      begin
         hold(K_SET, 5);
         hold('0, 0);
      end
      chk(disp_o.mode, ST_BROWSE);
   endtask

   initial
   begin
      cyc(4);
      rst_n <= 1'b1;
      cyc(2);
      t_reset();
      t_night();
      t_codes();
      t_menu();
      t_pass();
      results();
   end
endmodule
